// File: hdl/tpc_pwm.sv
/*
 three-phase pwm controller: timing unit, output control, gate drive
 and shutdown controller, with its register port.
 assumes clk is the instruction-rate clock and that all pins other
 than the shutdown sources are synchronous to it.
*/
// Overview of operation
// - six outputs form three high/low pairs for phases a, b and c.
// - polarity pin picks active-high or active-low on all six outputs.
// - period, dead-time, deletion and three duty registers set the waveforms.
// - each output has an enable bit; disabled outputs stay inactive.
// - per-phase crossover bit swaps the high and low waveforms.
// - eight-bit gate field sets the chopping frequency.
// - high-side and low-side chopping have separate enable bits.
// - single update mode latches new values only at period start.
// - double update mode also latches values at the period midpoint.
// - one mode register bit selects single or double update.
// - sync pulse at each period start, plus midpoint in double mode.
// - sync pulse width comes from the sync width register.
// - trip pin low forces all outputs off at once, unclocked.
// - selected port lines act as extra asynchronous trip sources.
// - hardware trip paths bypass all clocked logic.
// - writing the software trip register shuts the outputs down.
// - status shows trip level, polarity level and period half.
// - shutdown sources are combined into the timing unit reset.
// - all pwm timing runs on the instruction-rate clock.
// - one interrupt per sync pulse, one per shutdown event.
// - each phase gives complementary centred waveforms with dead time.
// - mode bit 6 set means double update; reset clears it.
// - status bit 3 is zero in first half, one in second.
// - sync pulse lasts width plus one clocks; width resets to 0x27.
// - dead time is twice the dead-time value in clocks; zero means none.
`timescale 1ns/1ps
`default_nettype none
module tpc_pwm
	import tpc_pkg::*;
#(
	parameter int PORT_LINES = 12
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire tpc_bus_req_t bus_req,
	output logic [DATA_W-1:0] bus_rdata,
	input wire logic trip_input_pin_n,
	input wire logic polarity_select_pin,
	input wire logic [PORT_LINES-1:0] port_lines,
	output logic phase_a_high_out,
	output logic phase_a_low_out,
	output logic phase_b_high_out,
	output logic phase_b_low_out,
	output logic phase_c_high_out,
	output logic phase_c_low_out,
	output logic sync_pulse_out,
	output logic sync_irq,
	output logic trip_irq
);

	// software-visible registers
	logic [15:0] period_r;
	logic [9:0] dead_r;
	logic [9:0] pdel_r;
	logic [15:0] duty_r [3];
	logic [8:0] seg_r;
	logic [9:0] gate_r;
	logic dbl_r;
	logic [7:0] syncwt_r;
	logic [PORT_LINES-1:0] portsel_r;
	logic [DATA_W-1:0] rdata_r;

	// values latched into the timing unit at update events
	logic [15:0] pt_l;
	logic [9:0] dt_l;
	logic [9:0] pd_l;
	logic [15:0] duty_l [3];
	logic [8:0] seg_l;
	logic [7:0] wt_l;

	// timing unit state
	logic [15:0] cnt_r;
	logic half_r;
	logic half_d_r;
	logic ev_start;
	logic ev_mid;
	logic ev;

	// waveform path
	logic [2:0] raw;
	logic [2:0] raw_q_r;
	logic [10:0] dt_cnt_r [3];
	logic [10:0] dt2;
	logic [2:0] hi_tu;
	logic [2:0] lo_tu;
	logic [5:0] act;
	logic [5:0] out_r;
	logic [7:0] gcnt_r;
	logic chop_r;

	// shutdown and sync
	logic hw_trip;
	logic sw_wr;
	logic clr_wr;
	logic shut_set;
	logic shut_r;
	logic trip_irq_r;
	logic sync_out_r;
	logic [7:0] sync_cnt_r;
	logic sync_irq_r;

	// one phase: high side on when centred count overlaps the duty,
	// pulses shorter than the deletion width are dropped entirely
	function automatic logic tpc_raw(
		input logic [15:0] cnt,
		input logic [15:0] duty,
		input logic [15:0] pt,
		input logic [9:0] pd
	);
		logic [16:0] on_t;
		logic [16:0] off_t;
		logic del_hi;
		logic del_lo;
		on_t = (duty > pt) ? {1'b0, pt} : {1'b0, duty};
		off_t = {1'b0, pt} - on_t;
		del_hi = {on_t[15:0], 1'b0} < {7'h00, pd};
		del_lo = {off_t[15:0], 1'b0} < {7'h00, pd};
		if (del_hi) begin
			return 1'b0;
		end
		if (del_lo) begin
			return 1'b1;
		end
		return ({1'b0, cnt} + on_t) >= {1'b0, pt};
	endfunction

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// register port write decode
	assign sw_wr = bus_req.wr && (bus_req.addr == OFS_SWTRIP);
	assign clr_wr = bus_req.wr && (bus_req.addr == OFS_STATUS);

	// configuration registers; unmapped writes are dropped
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			period_r <= RST_PERIOD;
			dead_r <= RST_DEAD;
			pdel_r <= RST_PDEL;
			duty_r[0] <= RST_DUTY;
			duty_r[1] <= RST_DUTY;
			duty_r[2] <= RST_DUTY;
			seg_r <= RST_SEG;
			gate_r <= RST_GATE;
			dbl_r <= 1'b0;
			syncwt_r <= RST_SYNCWT;
			portsel_r <= RST_PORTSEL;
		end else if (bus_req.wr) begin
			case (bus_req.addr)
				OFS_PERIOD: period_r <= bus_req.wdata;
				OFS_DEAD: dead_r <= bus_req.wdata[9:0];
				OFS_PDEL: pdel_r <= bus_req.wdata[9:0];
				OFS_DUTY_A: duty_r[0] <= bus_req.wdata;
				OFS_DUTY_B: duty_r[1] <= bus_req.wdata;
				OFS_DUTY_C: duty_r[2] <= bus_req.wdata;
				OFS_SEG: seg_r <= bus_req.wdata[8:0];
				OFS_GATE: gate_r <= bus_req.wdata[9:0];
				OFS_MODE: dbl_r <= bus_req.wdata[MODE_DBL_BIT];
				OFS_SYNCWT: syncwt_r <= bus_req.wdata[7:0];
				OFS_PORTSEL: portsel_r <= bus_req.wdata[PORT_LINES-1:0];
				default: ;
			endcase
		end
	end

	// read data stands for one cycle only, zero otherwise
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata_r <= 16'h0000;
		end else begin
			rdata_r <= 16'h0000;
			if (bus_req.rd) begin
				case (bus_req.addr)
					OFS_PERIOD: rdata_r <= period_r;
					OFS_DEAD: rdata_r <= {6'h00, dead_r};
					OFS_PDEL: rdata_r <= {6'h00, pdel_r};
					OFS_DUTY_A: rdata_r <= duty_r[0];
					OFS_DUTY_B: rdata_r <= duty_r[1];
					OFS_DUTY_C: rdata_r <= duty_r[2];
					OFS_SEG: rdata_r <= {7'h00, seg_r};
					OFS_GATE: rdata_r <= {6'h00, gate_r};
					OFS_MODE: rdata_r <= 16'(dbl_r) << MODE_DBL_BIT;
					OFS_SYNCWT: rdata_r <= {8'h00, syncwt_r};
					OFS_PORTSEL: rdata_r <= 16'(portsel_r);
					OFS_STATUS: begin
						rdata_r[STAT_TRIP] <= trip_input_pin_n;
						rdata_r[STAT_POL] <= polarity_select_pin;
						rdata_r[STAT_HALF] <= half_r;
						rdata_r[STAT_SHUT] <= shut_r;
						rdata_r[STAT_HW] <= hw_trip;
					end
					default: ;
				endcase
			end
		end
	end
	assign bus_rdata = rdata_r;

	status_half_a: assert property (bus_req.rd && bus_req.addr == OFS_STATUS
		|=> bus_rdata[STAT_HALF] == $past(half_r))
		else $error("status half bit does not follow the period half");

	// hardware trip: pin and selected port lines, no clock in the path
	assign hw_trip = !trip_input_pin_n || |(port_lines & portsel_r);
	assign shut_set = hw_trip || sw_wr;

	// shutdown latch; a new trip beats a clear in the same cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			shut_r <= 1'b0;
			trip_irq_r <= 1'b0;
		end else begin
			if (shut_set) begin
				shut_r <= 1'b1;
			end else if (clr_wr) begin
				shut_r <= 1'b0;
			end
			trip_irq_r <= shut_set && !shut_r;
		end
	end
	assign trip_irq = trip_irq_r;

	sw_trip_a: assert property (sw_wr |=> shut_r && trip_irq == !$past(shut_r))
		else $error("software trip did not shut down");

	// up/down counter, pt clocks per half; held at zero while shut down
	always_ff @(posedge clk) begin
		if (!rst_n || shut_r) begin
			cnt_r <= 16'h0000;
			half_r <= 1'b0;
			half_d_r <= 1'b0;
		end else begin
			half_d_r <= half_r;
			if (!half_r) begin
				if (({1'b0, cnt_r} + 17'h00001) >= {1'b0, pt_l}) begin
					half_r <= 1'b1;
				end else begin
					cnt_r <= cnt_r + 16'h0001;
				end
			end else if (cnt_r == 16'h0000) begin
				half_r <= 1'b0;
			end else begin
				cnt_r <= cnt_r - 16'h0001;
			end
		end
	end

	shut_reset_a: assert property (shut_r |=> cnt_r == 16'h0000 && !half_r)
		else $error("timing unit not held in reset during shutdown");

	// update events: period start always, midpoint only in double mode
	assign ev_start = !half_r && (cnt_r == 16'h0000) && !shut_r;
	assign ev_mid = half_r && !half_d_r && !shut_r;
	assign ev = ev_start || (dbl_r && ev_mid);

	// shadow latch; software may write at any time without glitching a period
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pt_l <= RST_PERIOD;
			dt_l <= RST_DEAD;
			pd_l <= RST_PDEL;
			duty_l[0] <= RST_DUTY;
			duty_l[1] <= RST_DUTY;
			duty_l[2] <= RST_DUTY;
			seg_l <= RST_SEG;
			wt_l <= RST_SYNCWT;
		end else if (ev) begin
			pt_l <= period_r;
			dt_l <= dead_r;
			pd_l <= pdel_r;
			duty_l[0] <= duty_r[0];
			duty_l[1] <= duty_r[1];
			duty_l[2] <= duty_r[2];
			seg_l <= seg_r;
			wt_l <= syncwt_r;
		end
	end

	single_hold_a: assert property (!ev |=> $stable(duty_l[0]) && $stable(pt_l))
		else $error("duty changed outside an update event");
	double_mid_a: assert property (ev_mid && dbl_r |=> duty_l[1] == $past(duty_r[1]))
		else $error("midpoint update missed in double mode");
	single_mid_a: assert property (ev_mid && !dbl_r |=> !sync_irq)
		else $error("midpoint event in single update mode");

	// dead-time counters restart on every edge of the raw waveform
	assign dt2 = 11'(dt_l) * 11'(DT_SCALE);
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			raw_q_r <= 3'h0;
			for (int i = 0; i < 3; i++) begin
				dt_cnt_r[i] <= DT_CNT_MAX;
			end
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (raw[i] != raw_q_r[i]) begin
					raw_q_r[i] <= raw[i];
					dt_cnt_r[i] <= 11'h000;
				end else if (dt_cnt_r[i] != DT_CNT_MAX) begin
					dt_cnt_r[i] <= dt_cnt_r[i] + 11'h001;
				end
			end
		end
	end

	dead_time_a: assert property ($rose(raw_q_r[0]) && dt_l != 10'h000 |-> !hi_tu[0])
		else $error("high side turned on without dead time");

	// timing unit, crossover, enables and chopping, per phase
	always_comb begin
		logic hs;
		logic ls;
		hs = 1'b0;
		ls = 1'b0;
		for (int i = 0; i < 3; i++) begin
			raw[i] = !shut_r && tpc_raw(cnt_r, duty_l[i], pt_l, pd_l);
			hi_tu[i] = raw_q_r[i] && (dt_cnt_r[i] >= dt2);
			lo_tu[i] = !raw_q_r[i] && (dt_cnt_r[i] >= dt2);
			hs = seg_l[SEG_XOV_LSB + i] ? lo_tu[i] : hi_tu[i];
			ls = seg_l[SEG_XOV_LSB + i] ? hi_tu[i] : lo_tu[i];
			act[2 * i] = hs && seg_l[2 * i]
				&& (!gate_r[GATE_HI_EN] || chop_r);
			act[2 * i + 1] = ls && seg_l[2 * i + 1]
				&& (!gate_r[GATE_LO_EN] || chop_r);
		end
	end

	// chopping carrier: toggles every div+1 clocks
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			gcnt_r <= 8'h00;
			chop_r <= 1'b0;
		end else if (gcnt_r >= gate_r[7:0]) begin
			gcnt_r <= 8'h00;
			chop_r <= !chop_r;
		end else begin
			gcnt_r <= gcnt_r + 8'h01;
		end
	end

	// gate drive: polarity applied last so every source sees active-high
	always_ff @(posedge clk) begin
		if (!rst_n || shut_r) begin
			out_r <= {6{!polarity_select_pin}};
		end else if (polarity_select_pin) begin
			out_r <= act;
		end else begin
			out_r <= ~act;
		end
	end

	enable_off_a: assert property (!seg_l[0] && !hw_trip
		&& $stable(polarity_select_pin) |=> out_r[0] == !polarity_select_pin)
		else $error("disabled output was driven active");
	xover_a: assert property (seg_l[SEG_XOV_LSB] && seg_l[0] && !gate_r[GATE_HI_EN]
		&& !shut_r && polarity_select_pin |=> out_r[0] == $past(lo_tu[0]))
		else $error("crossover did not route low waveform to high output");

	// trip override is combinational so a dead clock cannot hold outputs on;
	// the price is that these six pins are not purely registered
	assign phase_a_high_out = hw_trip ? !polarity_select_pin : out_r[0];
	assign phase_a_low_out = hw_trip ? !polarity_select_pin : out_r[1];
	assign phase_b_high_out = hw_trip ? !polarity_select_pin : out_r[2];
	assign phase_b_low_out = hw_trip ? !polarity_select_pin : out_r[3];
	assign phase_c_high_out = hw_trip ? !polarity_select_pin : out_r[4];
	assign phase_c_low_out = hw_trip ? !polarity_select_pin : out_r[5];

	trip_off_a: assert property (!trip_input_pin_n |-> phase_a_high_out == !polarity_select_pin
		&& phase_c_low_out == !polarity_select_pin)
		else $error("trip pin did not force outputs off");
	port_trip_a: assert property (|(port_lines & portsel_r)
		|-> phase_b_low_out == !polarity_select_pin)
		else $error("selected port line did not force outputs off");

	// sync pulse: width register plus one clocks, retriggered by each event
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync_out_r <= 1'b0;
			sync_cnt_r <= 8'h00;
			sync_irq_r <= 1'b0;
		end else begin
			sync_irq_r <= ev;
			if (ev) begin
				sync_out_r <= 1'b1;
				sync_cnt_r <= syncwt_r;
			end else if (sync_cnt_r == 8'h00) begin
				sync_out_r <= 1'b0;
			end else begin
				sync_cnt_r <= sync_cnt_r - 8'h01;
			end
		end
	end
	assign sync_pulse_out = sync_out_r;
	assign sync_irq = sync_irq_r;

	sync_width_a: assert property (ev |=> sync_pulse_out && sync_irq
		&& sync_cnt_r == $past(syncwt_r))
		else $error("sync pulse not started with programmed width");
	sync_short_a: assert property (ev && syncwt_r == 8'h01 && !dbl_r
		|=> sync_pulse_out [*2] ##1 (!sync_pulse_out || sync_irq))
		else $error("sync pulse width is not value plus one");

endmodule
`default_nettype wire

// File: inc/tpc_pkg.sv
/*
 three-phase pwm controller: register map, field positions, reset values
 and the bus request carrier shared by the design and its bench.
 assumes a 16-bit register port with a 4-bit word address.
*/
`default_nettype none
package tpc_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	// register offsets (word addresses on the register port)
	localparam logic [3:0] OFS_PERIOD = 4'h0;
	localparam logic [3:0] OFS_DEAD = 4'h1;
	localparam logic [3:0] OFS_PDEL = 4'h2;
	localparam logic [3:0] OFS_DUTY_A = 4'h3;
	localparam logic [3:0] OFS_DUTY_B = 4'h4;
	localparam logic [3:0] OFS_DUTY_C = 4'h5;
	localparam logic [3:0] OFS_SEG = 4'h6;
	localparam logic [3:0] OFS_GATE = 4'h7;
	localparam logic [3:0] OFS_MODE = 4'h8;
	localparam logic [3:0] OFS_SYNCWT = 4'h9;
	localparam logic [3:0] OFS_PORTSEL = 4'hA;
	localparam logic [3:0] OFS_SWTRIP = 4'hB;
	localparam logic [3:0] OFS_STATUS = 4'hC;
	// field positions
	localparam int SEG_XOV_LSB = 6;
	localparam int GATE_HI_EN = 8;
	localparam int GATE_LO_EN = 9;
	localparam int MODE_DBL_BIT = 6;
	localparam int STAT_TRIP = 0;
	localparam int STAT_POL = 1;
	localparam int STAT_HALF = 3;
	localparam int STAT_SHUT = 4;
	localparam int STAT_HW = 5;
	// reset values
	localparam logic [15:0] RST_PERIOD = 16'h0100;
	localparam logic [9:0] RST_DEAD = 10'h000;
	localparam logic [9:0] RST_PDEL = 10'h000;
	localparam logic [15:0] RST_DUTY = 16'h0000;
	localparam logic [8:0] RST_SEG = 9'h03F;
	localparam logic [9:0] RST_GATE = 10'h000;
	localparam logic [7:0] RST_SYNCWT = 8'h27;
	localparam logic [11:0] RST_PORTSEL = 12'h000;
	// timing: dead time counts two clocks per register step
	localparam int DT_SCALE = 2;
	localparam logic [10:0] DT_CNT_MAX = 11'h7FF;
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} tpc_bus_req_t;
endpackage
`default_nettype wire

// File: test/tb_three_phase_pwm_controller.sv
/*
 bench for the three-phase pwm controller: register port, sync timing,
 output control, dead time and the shutdown paths.
 assumes the register map and reset values of tpc_pkg.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_three_phase_pwm_controller
	import tpc_pkg::*;
;
	logic clk, rst_n, trip_n, pol, sync_out, sync_irq, trip_irq, rd_d, sync_q;
	logic [11:0] port_lines;
	tpc_bus_req_t req;
	logic [15:0] rdata, shoots, e, m;
	logic [5:0] gates;
	logic [15:0] exp_q[$];
	logic [15:0] msk_q[$];
	logic [15:0] segs[4] = '{16'h003F, 16'h007F, 16'h007E, 16'h007D};
	logic [1:0] pairs[4] = '{2'b10, 2'b01, 2'b00, 2'b01};
	int fails, cmp_count, cyc, rise_cyc, width_r, gap_r, rises, sirqs, tirqs;
	int ah_n, al_n, seed, w, h0, l0, r0;
	tpc_pwm #(.PORT_LINES(12)) uut (
		.clk(clk), .rst_n(rst_n), .bus_req(req), .bus_rdata(rdata),
		.trip_input_pin_n(trip_n), .polarity_select_pin(pol), .port_lines(port_lines),
		.phase_a_high_out(gates[0]), .phase_a_low_out(gates[1]),
		.phase_b_high_out(gates[2]), .phase_b_low_out(gates[3]),
		.phase_c_high_out(gates[4]), .phase_c_low_out(gates[5]),
		.sync_pulse_out(sync_out), .sync_irq(sync_irq), .trip_irq(trip_irq)
	);
	tpc_gate_model legs (.clk(clk), .pol(pol), .gates(gates), .shoots(shoots));
	// 100 MHz clock
	always #5 clk = ~clk;
	task automatic summarize;
		$display("counts: %0d compares, %0d mismatches", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// bus tasks are entered just after a rising edge and leave on the taking edge
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] exp, input logic [15:0] msk);
		exp_q.push_back(exp);
		msk_q.push_back(msk);
		req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
	endtask
	task automatic tick(input int n);
		req <= '{addr: 4'h0, wdata: 16'h0000, wr: 1'b0, rd: 1'b0};
		repeat (n) @(posedge clk);
	endtask
	// bounded wait for further sync rises; running out ends the run
	task automatic wait_rises(input int n);
		int t0;
		t0 = rises;
		for (int i = 0; i < 3000 && rises < t0 + n; i++) begin
			@(negedge clk);
		end
		if (rises < t0 + n) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, rises, t0 + n);
			summarize();
		end
	endtask
	task automatic sync_check(input int wid, input int gap);
		int s0;
		int q0;
		@(negedge clk);
		s0 = sirqs;
		q0 = rises;
		wait_rises(2);
		chk(16'(width_r), 16'(wid));
		chk(16'(gap_r), 16'(gap));
		chk(16'(sirqs - s0), 16'(rises - q0));
		@(posedge clk);
	endtask
	// result watcher: oldest expected read off the queue, sync timing, pulse counts
	always @(posedge clk) begin
		cyc++;
		if (rd_d) begin
			e = exp_q.pop_front();
			m = msk_q.pop_front();
			chk(rdata & m, e);
		end
		if (sync_out && !sync_q) begin
			gap_r = cyc - rise_cyc;
			rise_cyc = cyc;
			rises++;
		end
		if (!sync_out && sync_q) begin
			width_r = cyc - rise_cyc;
		end
		sirqs += int'(sync_irq);
		tirqs += int'(trip_irq);
		ah_n += int'(gates[0]);
		al_n += int'(gates[1]);
		rd_d <= req.rd;
		sync_q <= sync_out;
	end
	// main sequence
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		trip_n = 1'b1;
		pol = 1'b1;
		port_lines = 12'h000;
		req = '{addr: 4'h0, wdata: 16'h0000, wr: 1'b0, rd: 1'b0};
		seed = 32'hc956;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(OFS_SYNCWT, 16'h0027, 16'h00FF);
		rd(OFS_PERIOD, RST_PERIOD, 16'hFFFF);
		rd(OFS_MODE, 16'h0000, 16'h0040);
		rd(OFS_SEG, 16'h003F, 16'h01FF);
		rd(OFS_STATUS, 16'h0003, 16'h0013);
		rd(OFS_SWTRIP, 16'h0000, 16'hFFFF);
		rd(4'hD, 16'h0000, 16'hFFFF);
		tick(2);
		sync_check(40, 512);
		$display("reset values and default sync done");
		// single then double update, random sync width
		for (int md = 0; md < 2; md++) begin
			w = $random(seed) & 3;
			wr(OFS_PERIOD, 16'h0008);
			wr(OFS_SYNCWT, 16'(w));
			wr(OFS_MODE, (md != 0) ? 16'h0040 : 16'h0000);
			tick(600);
			sync_check(w + 1, (md != 0) ? 8 : 16);
		end
		$display("update modes done");
		// duty 0 on phase a: crossover and per-pin enables
		wr(OFS_MODE, 16'h0000);
		wr(OFS_DUTY_A, 16'h0000);
		for (int k = 0; k < 4; k++) begin
			wr(OFS_SEG, segs[k]);
			tick(40);
			@(negedge clk);
			chk({14'h0000, gates[1:0]}, {14'h0000, pairs[k]});
			@(posedge clk);
		end
		$display("output control done");
		// half duty on phase a: active time shrinks by twice the dead-time value per turn-on edge
		wr(OFS_SEG, 16'h003F);
		wr(OFS_DUTY_A, 16'h0004);
		for (int dt = 0; dt < 3; dt++) begin
			wr(OFS_DUTY_B, 16'($random(seed)) & 16'h0007);
			wr(OFS_DUTY_C, 16'($random(seed)) & 16'h0007);
			wr(OFS_DEAD, 16'(dt));
			tick(40);
			@(negedge clk);
			h0 = ah_n;
			l0 = al_n;
			repeat (32) @(negedge clk);
			chk(16'(ah_n - h0), 16'(16 - 4 * dt));
			chk(16'(al_n - l0), 16'(16 - 4 * dt));
			@(posedge clk);
		end
		$display("dead time done");
		// high-side chopping, divider 1: full-on high side is on half of the time
		wr(OFS_DEAD, 16'h0000);
		wr(OFS_DUTY_A, 16'hFFFF);
		wr(OFS_GATE, 16'h0101);
		tick(40);
		@(negedge clk);
		h0 = ah_n;
		repeat (32) @(negedge clk);
		chk(16'(ah_n - h0), 16'h0010);
		@(posedge clk);
		wr(OFS_GATE, 16'h0000);
		$display("chopping done");
		// trip pin in both polarities, phase a high side held fully on
		wr(OFS_DUTY_A, 16'hFFFF);
		for (int p = 0; p < 2; p++) begin
			pol <= p[0];
			tick(40);
			@(negedge clk);
			chk({15'h0000, gates[0]}, {15'h0000, pol});
			@(posedge clk);
			trip_n <= 1'b0;
			@(negedge clk);
			chk({10'h000, gates}, {10'h000, {6{~pol}}});
			@(posedge clk);
			rd(OFS_STATUS, {10'h000, 4'b1100, pol, 1'b0}, 16'h0033);
			trip_n <= 1'b1;
			wr(OFS_STATUS, 16'h0000);
		end
		// port line shutdown: unselected line ignored, selected line trips at once
		wr(OFS_PORTSEL, 16'h0020);
		tick(40);
		port_lines <= 12'h008;
		@(negedge clk);
		chk({15'h0000, gates[0]}, 16'h0001);
		@(posedge clk);
		port_lines <= 12'h020;
		@(negedge clk);
		chk({10'h000, gates}, 16'h0000);
		@(posedge clk);
		port_lines <= 12'h000;
		wr(OFS_STATUS, 16'h0000);
		tick(40);
		$display("hardware shutdown done");
		// software trip stops outputs and the timing unit
		wr(OFS_SWTRIP, 16'h0001);
		tick(3);
		@(negedge clk);
		chk({10'h000, gates}, 16'h0000);
		r0 = rises;
		repeat (40) @(negedge clk);
		chk(16'(rises - r0), 16'h0000);
		@(posedge clk);
		rd(OFS_STATUS, 16'h0011, 16'h0031);
		wr(OFS_STATUS, 16'h0000);
		tick(3);
		@(negedge clk);
		chk(16'(tirqs), 16'h0004);
		chk(shoots, 16'h0000);
		$display("software shutdown done");
		summarize();
	end
endmodule
`default_nettype wire

// File: test/tpc_gate_model.sv
/*
 gate driver model: stands for the inverter legs behind the six gate outputs
 and counts the cycles in which both switches of one leg would conduct.
 assumes one clock domain and that pol gives the active gate level.
*/
`timescale 1ns/1ps
`default_nettype none
module tpc_gate_model (
	input wire logic clk,
	input wire logic pol,
	input wire logic [5:0] gates,
	output logic [15:0] shoots
);
	logic [2:0] leg_on;
	logic pol_q;
	// registered gates follow the polarity of the previous cycle, so a pin flip
	// must not be read as both switches of a leg conducting
	always @(posedge clk) begin
		pol_q <= pol;
	end
	// a leg shorts the dc link when both of its switches see the active level
	assign leg_on[0] = (gates[1:0] == {2{pol_q}});
	assign leg_on[1] = (gates[3:2] == {2{pol_q}});
	assign leg_on[2] = (gates[5:4] == {2{pol_q}});
	initial shoots = 16'h0000;
	// sampled mid-cycle so that registered output changes have landed
	always @(negedge clk) begin
		if (|leg_on) begin
			shoots <= shoots + 16'h0001;
		end
	end
endmodule
`default_nettype wire
